// ### design/ssrm_pkg.sv
// Purpose: Constants, register map and helper functions of the serial slave register map.
// Assumes: One clock at 250 MHz; holding registers are addressed by their register number.
// Notes:   Wire address 0 corresponds to register number REG_NUM_BASE.
package ssrm_pkg;

  // ==========================================================================
  // Clock, line timing and framing
  // ==========================================================================
  localparam int          CLK_HZ         = 250_000_000;
  localparam int          CHAR_BITS      = 11;
  localparam int          GAP_HALF_CHARS = 7;
  // Silence ending a frame: 3.5 characters, rounded up to whole bit times.
  localparam int          GAP_BITS       = (GAP_HALF_CHARS * CHAR_BITS + 1) / 2;
  localparam logic [3:0]  RX_BITS        = 4'h9;
  localparam logic        MODE_AUTO      = 1'b0;
  localparam logic        MODE_FIXED     = 1'b1;
  localparam logic [1:0]  PAR_NONE       = 2'h0;
  localparam logic [1:0]  PAR_EVEN       = 2'h1;
  localparam logic [1:0]  PAR_ODD        = 2'h2;
  localparam logic [7:0]  DEFAULT_SLAVE  = 8'h01;
  localparam logic [15:0] CRC_INIT       = 16'hFFFF;
  localparam logic [15:0] CRC_POLY       = 16'hA001;

  // ==========================================================================
  // Function codes, exceptions and command fault codes
  // ==========================================================================
  localparam logic [7:0]  FC_READ        = 8'h03;
  localparam logic [7:0]  FC_WRITE_ONE   = 8'h05;
  localparam logic [7:0]  FC_WRITE_MANY  = 8'h10;
  localparam logic [7:0]  EXC_FLAG       = 8'h80;
  localparam logic [7:0]  EXC_FUNC       = 8'h01;
  localparam logic [7:0]  EXC_ADDR       = 8'h02;
  localparam logic [7:0]  EXC_VALUE      = 8'h03;
  localparam logic [15:0] FAULT_NONE     = 16'h0000;
  localparam logic [15:0] FAULT_COUNT    = 16'h0064;
  localparam logic [15:0] FAULT_READONLY = 16'h0065;
  localparam logic [15:0] FAULT_LENGTH   = 16'h0066;

  // Byte positions inside a request, and fixed lengths; request lengths include the check word, reply lengths do not.
  localparam int          B_ADDR         = 0;
  localparam int          B_FC           = 1;
  localparam int          B_START        = 2;
  localparam int          B_COUNT        = 4;
  localparam int          B_BYTES        = 6;
  localparam int          B_DATA_MANY    = 7;
  localparam logic [7:0]  REQ_LEN        = 8'h08;
  localparam logic [7:0]  MANY_HDR_LEN   = 8'h09;
  localparam logic [7:0]  EXC_LEN        = 8'h03;
  localparam logic [7:0]  ECHO_LEN       = 8'h06;
  localparam logic [7:0]  READ_HDR_LEN   = 8'h03;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int          NUM_VALUES     = 23;
  localparam logic [15:0] REG_NUM_BASE   = 16'h9C41;
  localparam logic [15:0] FLT_AREA_BASE  = 16'h9D08;
  localparam logic [15:0] SWP_AREA_BASE  = 16'hB090;
  localparam logic [1:0]  TRIPLE_LAST    = 2'h2;
  localparam int          WORD_W         = 16;
  localparam logic [4:0]  IDX_CMD_FAULT  = 5'h04;
  localparam logic [4:0]  IDX_CMD        = 5'h0F;
  localparam logic [4:0]  IDX_NO_EFFECT  = 5'h12;
  // Integer area register numbers, value index 0 at the right.
  localparam logic [NUM_VALUES-1:0][15:0] INT_OFS = {
    16'h9C6F, 16'h9C6E, 16'h9C6D, 16'h9C6C, 16'h9C6B, 16'h9C62, 16'h9C5F, 16'h9C5E,
    16'h9C5B, 16'h9C58, 16'h9C55, 16'h9C52, 16'h9C4F, 16'h9C4C, 16'h9C4B, 16'h9C4A,
    16'h9C49, 16'h9C48, 16'h9C47, 16'h9C44, 16'h9C43, 16'h9C42, 16'h9C41};
  // Values that take three registers in the integer area.
  localparam logic [NUM_VALUES-1:0]       TRIPLE  = 23'h037E08;

  typedef enum logic [1:0] {AREA_INT, AREA_FLT, AREA_SWP} ssrm_area_e;

  typedef struct packed {
    logic       hit;
    logic [4:0] idx;
    logic [1:0] part;
    ssrm_area_e area;
    logic       last;
  } ssrm_hit_s;

  // Float slot of each value; the float areas leave gaps after the serial number.
  function automatic logic [14:0] ssrm_slot(input int i);
    int s;
    s = (i < 3) ? i : (i < 18) ? i + 1 : i + 3;
    return 15'(s);
  endfunction

  function automatic ssrm_hit_s ssrm_decode(input logic [15:0] num);
    ssrm_hit_s   r;
    logic [15:0] off;
    logic [15:0] fo;
    logic [15:0] so;
    r  = '0;
    fo = num - FLT_AREA_BASE;
    so = num - SWP_AREA_BASE;
    for (int i = 0; i < NUM_VALUES; i++) begin
      off = num - INT_OFS[i];
      if (off == 16'h0000 || (TRIPLE[i] && off <= {14'h0, TRIPLE_LAST})) begin
        r = '{1'b1, 5'(i), off[1:0], AREA_INT, (off[1:0] == (TRIPLE[i] ? TRIPLE_LAST : 2'h0))};
      end
      if (fo[15:1] == ssrm_slot(i)) begin
        r = '{1'b1, 5'(i), {1'b0, fo[0]}, AREA_FLT, fo[0]};
      end
      if (so[15:1] == ssrm_slot(i)) begin
        r = '{1'b1, 5'(i), {1'b0, so[0]}, AREA_SWP, so[0]};
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] ssrm_crc(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage

// ### design/ssrm_slave.sv
// Purpose: Serial slave answering a polling master from the holding register map.
// Assumes: Configuration inputs come from logic on mclk_i; line pins are asynchronous.
// Notes:   One protocol engine serves the port chosen by the configuration inputs.
// Functional notes
// - First port offers RS-232 or RS-485, only one active at a time.
// - Second port works over RS-485 only.
// - Shared line: one driver at a time, half duplex turn taking.
// - Master starts every exchange; device only replies to commands addressed to it.
// - Only binary RTU framing is accepted; ASCII framing is not supported.
// - Commands that cannot be performed get an exception reply; only exception 03 also stores a fault record.
// - Slave address defaults to 1; devices sharing a line need distinct addresses.
// - Automatic mode detects the line baud rate from incoming traffic.
// - Fixed mode uses the configured baud rate and data format.
// - Read with function 03; write with 05 single or 16 multiple.
// - Several adjacent registers may be read in one command.
// - Each value appears in integer, float and word-swapped float areas.
// - Reading the command register always returns zero.
// - Writes to external I/O and level status registers succeed but change nothing.
// - Device kind code is readable at both float area addresses.
// - With expansion units attached, the second port is not for the master.
// - Exception 03 stores a specific fault code; zero means no error.
`default_nettype none
`timescale 1ns/100ps

module ssrm_slave #(
  parameter int DIV_W        = 18,
  parameter int DEFAULT_BAUD = 9600,
  parameter int MAX_REGS     = 32,
  parameter int MIN_PULSE    = 16
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic             port_protocol_select_i,
  input  wire logic [1:0]       parity_mode_i,
  input  wire logic [DIV_W-1:0] baud_div_i,
  input  wire logic [7:0]       slave_addr_i,
  input  wire logic             com1_rs485_i,
  input  wire logic             master_on_com2_i,
  input  wire logic             expansion_link_i,
  input  wire logic             rs232_rxd_i,
  output logic                  rs232_txd_o,
  input  wire logic             com1_485_rxd_i,
  output logic                  com1_485_txd_o,
  output logic                  com1_485_oe_o,
  input  wire logic             com2_485_rxd_i,
  output logic                  com2_485_txd_o,
  output logic                  com2_485_oe_o,
  output logic [4:0]            val_idx_o,
  input  wire logic [47:0]      val_int_i,
  input  wire logic [31:0]      val_flt_i,
  output logic                  wr_o,
  output logic [4:0]            wr_idx_o,
  output ssrm_pkg::ssrm_area_e  wr_area_o,
  output logic [47:0]           wr_data_o
);
  import ssrm_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  localparam int BUF_LEN = 2 * MAX_REGS + 9;
  localparam int GAP_W   = DIV_W + 6;
  localparam logic [DIV_W-1:0] DEF_DIV = DIV_W'(CLK_HZ / DEFAULT_BAUD);

  typedef enum logic [2:0] {ST_RX, ST_CHECK, ST_FETCH, ST_LOAD, ST_WRITE, ST_TX} ssrm_main_e;

  typedef struct packed {
    ssrm_main_e                st;
    logic [2:0]                sync1;
    logic [2:0]                sync2;
    logic                      rx_prev;
    logic                      rx_busy;
    logic [DIV_W-1:0]          rx_cnt;
    logic [3:0]                rx_bit;
    logic [8:0]                rx_sh;
    logic [GAP_W-1:0]          quiet;
    logic [DIV_W-1:0]          low_cnt;
    logic [DIV_W-1:0]          frame_min;
    logic [DIV_W-1:0]          auto_div;
    logic [BUF_LEN-1:0][7:0]   buff;
    logic [7:0]                len;
    logic                      bad;
    logic [15:0]               crc;
    logic [DIV_W-1:0]          tx_cnt;
    logic [3:0]                tx_bit;
    logic [10:0]               tx_sh;
    logic [7:0]                tx_pos;
    logic [15:0]               tx_crc;
    logic [7:0]                fc;
    logic [15:0]               start;
    logic [15:0]               count;
    logic [15:0]               j;
    logic [15:0]               fault;
    logic [4:0]                val_idx;
    logic [47:0]               stage;
    logic                      wr;
    logic [4:0]                wr_idx;
    ssrm_area_e                wr_area;
    logic [47:0]               wr_data;
  } ssrm_state_s;

  ssrm_state_s      q;
  ssrm_state_s      n;
  logic             use2;
  logic             rxd;
  logic             driving;
  logic [DIV_W-1:0] div;
  logic [GAP_W-1:0] gap_lim;
  logic [7:0]       my_addr;

  assign use2    = master_on_com2_i && !expansion_link_i;
  assign my_addr = (slave_addr_i == 8'h00) ? DEFAULT_SLAVE : slave_addr_i;
  assign div     = (port_protocol_select_i == MODE_FIXED) ? baud_div_i
                                                          : q.auto_div;
  assign gap_lim = GAP_W'(div) * GAP_W'(GAP_BITS);
  assign driving = (q.st == ST_TX);

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    logic        pin;
    logic [8:0]  sh;
    logic        par_ok;
    logic [7:0]  exc;
    logic [15:0] exc_fault;
    logic        go_tx;
    ssrm_hit_s   h;
    logic [15:0] w;
    logic [7:0]  b;
    logic [7:0]  pos;
    int          wpos;
    pin       = 1'b1;
    sh        = '0;
    par_ok    = 1'b0;
    exc       = 8'h00;
    exc_fault = FAULT_NONE;
    go_tx     = 1'b0;
    w         = '0;
    b         = '0;
    wpos      = 0;
    pos       = 8'(q.j << 1);
    h         = ssrm_decode(REG_NUM_BASE + q.start + q.j);
    n         = q;
    n.wr      = 1'b0;
    n.sync1   = {com2_485_rxd_i, com1_485_rxd_i, rs232_rxd_i};
    n.sync2   = q.sync1;
    // Com 2 has no RS-232 receiver; com 1 takes one of its two physical layers.
    pin = use2 ? q.sync2[2] : (com1_rs485_i ? q.sync2[1] : q.sync2[0]);
    // Our own transmission echoes back on a 2-wire line, so receive is blind meanwhile.
    rxd = driving ? 1'b1 : pin;
    n.rx_prev = rxd;

    // Shortest low pulse of the frame is one bit time; glitches are ignored.
    if (!rxd) begin
      if (q.low_cnt != '1) n.low_cnt = q.low_cnt + 1'b1;
    end else begin
      if (!q.rx_prev && q.low_cnt >= DIV_W'(MIN_PULSE) && q.low_cnt < q.frame_min) begin
        n.frame_min = q.low_cnt;
      end
      n.low_cnt = '0;
    end

    // Character receiver, sampling mid-bit.
    if (!q.rx_busy) begin
      if (!rxd && q.st == ST_RX) begin
        n.rx_busy = 1'b1;
        n.rx_cnt  = div >> 1;
        n.rx_bit  = '0;
      end
    end else if (q.rx_cnt != '0) begin
      n.rx_cnt = q.rx_cnt - 1'b1;
    end else begin
      n.rx_cnt = div - 1'b1;
      sh       = {rxd, q.rx_sh[8:1]};
      if (q.rx_bit == '0) begin
        if (rxd) n.rx_busy = 1'b0;
        n.rx_bit = 4'h1;
      end else begin
        n.rx_sh  = sh;
        n.rx_bit = q.rx_bit + 1'b1;
        if (q.rx_bit == RX_BITS) begin
          n.rx_busy = 1'b0;
          unique case (parity_mode_i)
            PAR_EVEN: par_ok = ~^sh;
            PAR_ODD:  par_ok = ^sh;
            default:  par_ok = sh[8];
          endcase
          if (!par_ok || q.len == 8'(BUF_LEN)) n.bad = 1'b1;
          else begin
            n.buff[q.len] = sh[7:0];
            n.len         = q.len + 1'b1;
            n.crc         = ssrm_crc(q.crc, sh[7:0]);
          end
        end
      end
    end
    if (q.rx_busy || !rxd) n.quiet = '0;
    else if (q.quiet != '1) n.quiet = q.quiet + 1'b1;

    unique case (q.st)
      ST_RX: begin
        if (q.len != 8'h00 && q.quiet >= gap_lim) begin
          n.len       = '0;
          n.bad       = 1'b0;
          n.crc       = CRC_INIT;
          n.frame_min = '1;
          n.j         = '0;
          n.fc        = q.buff[B_FC];
          n.start     = {q.buff[B_START], q.buff[B_START+1]};
          n.count     = {q.buff[B_COUNT], q.buff[B_COUNT+1]};
          // A failed check word means a foreign framing or a wrong rate: relearn.
          if (q.bad || q.crc != 16'h0000) begin
            if (port_protocol_select_i == MODE_AUTO && q.frame_min != '1) begin
              n.auto_div = q.frame_min;
            end
          end else if (q.buff[B_ADDR] == my_addr) begin
            unique case (q.buff[B_FC])
              FC_READ, FC_WRITE_ONE: begin
                if (q.len != REQ_LEN) begin
                  exc       = EXC_VALUE;
                  exc_fault = FAULT_LENGTH;
                end else if (q.buff[B_FC] == FC_WRITE_ONE) begin
                  n.count = 16'h0001;
                  n.st    = ST_CHECK;
                end else if (n.count == '0 || n.count > 16'(MAX_REGS)) begin
                  exc       = EXC_VALUE;
                  exc_fault = FAULT_COUNT;
                end else n.st = ST_CHECK;
              end
              FC_WRITE_MANY: begin
                if (n.count == '0 || n.count > 16'(MAX_REGS)) begin
                  exc       = EXC_VALUE;
                  exc_fault = FAULT_COUNT;
                end else if (q.buff[B_BYTES] != 8'(n.count << 1)
                             || q.len != MANY_HDR_LEN + 8'(n.count << 1)) begin
                  exc       = EXC_VALUE;
                  exc_fault = FAULT_LENGTH;
                end else n.st = ST_CHECK;
              end
              default: exc = EXC_FUNC;
            endcase
          end
        end
      end
      ST_CHECK: begin
        // Every register of the range is checked before anything is read or written.
        if (!h.hit) exc = EXC_ADDR;
        else if (q.fc != FC_READ && h.idx < IDX_CMD) begin
          exc       = EXC_VALUE;
          exc_fault = FAULT_READONLY;
        end else if (q.j == q.count - 1'b1) begin
          n.j  = '0;
          n.st = (q.fc == FC_READ) ? ST_FETCH : ST_WRITE;
        end else n.j = q.j + 1'b1;
      end
      ST_FETCH: begin
        n.val_idx = h.idx;
        n.st      = ST_LOAD;
      end
      ST_LOAD: begin
        unique case (h.area)
          AREA_FLT: w = h.part[0] ? val_flt_i[15:0] : val_flt_i[31:16];
          AREA_SWP: w = h.part[0] ? val_flt_i[31:16] : val_flt_i[15:0];
          default: begin
            wpos = TRIPLE[h.idx] ? int'(TRIPLE_LAST - h.part) * WORD_W : 0;
            w    = val_int_i[wpos +: WORD_W];
          end
        endcase
        if (h.idx == IDX_CMD_FAULT) w = (h.area == AREA_INT || h.part[0]) ? q.fault : '0;
        if (h.idx == IDX_CMD) w = '0;
        n.buff[READ_HDR_LEN + pos]      = w[15:8];
        n.buff[READ_HDR_LEN + pos + 1'b1] = w[7:0];
        if (q.j == q.count - 1'b1) begin
          n.buff[B_COUNT-2] = 8'(q.count << 1);
          n.len             = READ_HDR_LEN + 8'(q.count << 1);
          go_tx             = 1'b1;
        end else begin
          n.j  = q.j + 1'b1;
          n.st = ST_FETCH;
        end
      end
      ST_WRITE: begin
        w = (q.fc == FC_WRITE_ONE) ? {q.buff[B_COUNT], q.buff[B_COUNT+1]}
                                   : {q.buff[B_DATA_MANY + pos], q.buff[B_DATA_MANY + pos + 1'b1]};
        unique case (h.area)
          AREA_FLT: wpos = h.part[0] ? 0 : WORD_W;
          AREA_SWP: wpos = h.part[0] ? WORD_W : 0;
          default:  wpos = TRIPLE[h.idx] ? int'(TRIPLE_LAST - h.part) * WORD_W : 0;
        endcase
        if (h.area == AREA_INT && !TRIPLE[h.idx]) n.stage = '0;
        n.stage[wpos +: WORD_W] = w;
        // Only a value written up to its last register is handed on.
        if (h.last && h.idx < IDX_NO_EFFECT) begin
          n.wr      = 1'b1;
          n.wr_idx  = h.idx;
          n.wr_area = h.area;
          n.wr_data = n.stage;
        end
        if (q.j == q.count - 1'b1) begin
          n.fault = FAULT_NONE;
          n.len   = ECHO_LEN;
          go_tx   = 1'b1;
        end else n.j = q.j + 1'b1;
      end
      ST_TX: begin
        if (q.tx_cnt != '0) n.tx_cnt = q.tx_cnt - 1'b1;
        else begin
          n.tx_cnt = div - 1'b1;
          if (q.tx_bit == 4'(CHAR_BITS) && q.tx_pos == q.len + 8'h02) begin
            n.st  = ST_RX;
            n.len = '0;
          end else if (q.tx_bit == '0 || q.tx_bit == 4'(CHAR_BITS)) begin
            if (q.tx_pos < q.len) begin
              b        = q.buff[q.tx_pos];
              n.tx_crc = ssrm_crc(q.tx_crc, b);
            end else b = (q.tx_pos == q.len) ? q.tx_crc[7:0] : q.tx_crc[15:8];
            unique case (parity_mode_i)
              PAR_EVEN: n.tx_sh = {1'b1, ^b, b, 1'b0};
              PAR_ODD:  n.tx_sh = {1'b1, ~^b, b, 1'b0};
              default:  n.tx_sh = {2'b11, b, 1'b0};
            endcase
            n.tx_pos = q.tx_pos + 1'b1;
            n.tx_bit = 4'h1;
          end else begin
            n.tx_sh  = {1'b1, q.tx_sh[10:1]};
            n.tx_bit = q.tx_bit + 1'b1;
          end
        end
      end
      default: n.st = ST_RX;
    endcase

    if (exc != 8'h00) begin
      n.buff[B_FC]     = q.buff[B_FC] | EXC_FLAG;
      n.buff[B_FC + 1] = exc;
      n.len            = EXC_LEN;
      go_tx            = 1'b1;
      if (exc == EXC_VALUE) n.fault = exc_fault;
    end
    if (go_tx) begin
      n.st     = ST_TX;
      n.tx_pos = '0;
      n.tx_bit = '0;
      n.tx_cnt = '0;
      n.tx_crc = CRC_INIT;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q           <= '0;
      q.sync1     <= '1;
      q.sync2     <= '1;
      q.rx_prev   <= 1'b1;
      q.frame_min <= '1;
      q.auto_div  <= DEF_DIV;
      q.crc       <= CRC_INIT;
      q.tx_sh     <= '1;
      q.tx_crc    <= CRC_INIT;
    end else begin
      q <= n;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Idle line is high; only the active port's driver is ever enabled.
  assign rs232_txd_o    = (!use2 && !com1_rs485_i) ? q.tx_sh[0] : 1'b1;
  assign com1_485_txd_o = (!use2 && com1_rs485_i) ? q.tx_sh[0] : 1'b1;
  assign com1_485_oe_o  = driving && !use2 && com1_rs485_i;
  assign com2_485_txd_o = use2 ? q.tx_sh[0] : 1'b1;
  assign com2_485_oe_o  = driving && use2;
  assign val_idx_o      = q.val_idx;
  assign wr_o           = q.wr;
  assign wr_idx_o       = q.wr_idx;
  assign wr_area_o      = q.wr_area;
  assign wr_data_o      = q.wr_data;

endmodule
`default_nettype wire

// ### testbench/ssrm_slave_asserts.sv
// Purpose: Port checks for the serial slave.
// Assumes: One clock domain; reset is active high.
// Notes:   Bound to every ssrm_slave instance.
`timescale 1ns/100ps
`default_nettype none
module ssrm_chk (
  input wire logic       mclk_i,
  input wire logic       rst_i,
  input wire logic       expansion_link_i,
  input wire logic       com1_485_txd_o,
  input wire logic       com1_485_oe_o,
  input wire logic       com2_485_oe_o,
  input wire logic       wr_o,
  input wire logic [4:0] wr_idx_o,
  input wire logic [4:0] val_idx_o
);
  // ==========================================================================
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_one_driver: assert property (!(com1_485_oe_o && com2_485_oe_o))
    else $error("two drivers");
  a_idle_high: assert property (!com1_485_oe_o |-> com1_485_txd_o)
    else $error("line low while released");
  a_com2_kept: assert property (expansion_link_i |-> !com2_485_oe_o)
    else $error("reserved port driven");
  a_reply_start: assert property ($rose(com1_485_oe_o) |-> ##[0:3] !com1_485_txd_o)
    else $error("no start bit");
  a_oe_stands: assert property ($rose(com1_485_oe_o) |=> com1_485_oe_o [*8])
    else $error("reply cut short");
  a_wr_pulse: assert property (wr_o |=> !wr_o)
    else $error("long write strobe");
  a_wr_target: assert property (wr_o |-> wr_idx_o inside {5'h0F, 5'h10, 5'h11})
    else $error("write to fixed value");
  a_wr_quiet: assert property (wr_o |-> !$past(com1_485_oe_o))
    else $error("write during reply");
  a_idx_range: assert property (val_idx_o <= 5'h16)
    else $error("value index out of range");
  c_reply: cover property ($rose(com1_485_oe_o));
  c_cmd_wr: cover property (wr_o && wr_idx_o == 5'h0F);
  c_trip_wr: cover property (wr_o && wr_idx_o == 5'h10);
endmodule
bind ssrm_slave ssrm_chk i_chk (.mclk_i(mclk_i), .rst_i(rst_i), .wr_o(wr_o),
  .expansion_link_i(expansion_link_i), .com1_485_txd_o(com1_485_txd_o),
  .com1_485_oe_o(com1_485_oe_o), .com2_485_oe_o(com2_485_oe_o),
  .wr_idx_o(wr_idx_o), .val_idx_o(val_idx_o));
`default_nettype wire

// ### testbench/ssrm_master.sv
// Purpose: Polling master on the shared RS-485 line.
// Assumes: Bit time of DIV clocks, no parity, two stop bits.
// Notes:   Returns the reply without its check word, or EE if that word is wrong.
`timescale 1ns/100ps
`default_nettype none
module ssrm_master #(parameter int DIV = 10) (
  input  wire logic mclk_i,
  input  wire logic line_i,
  output var logic  drv_o
);
  initial drv_o = 1'b1;
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction
  // The master listens long after its frame, so a slow reply is never cut off.
  task automatic xfer(input logic [7:0] q[$], output logic [7:0] r[$]);
    logic [15:0] c;
    logic [10:0] f;
    logic [7:0]  v;
    int          idle;
    c = crc(q);
    q = {q, c[7:0], c[15:8]};
    foreach (q[i]) begin
      f = {2'b11, q[i], 1'b0};
      for (int b = 0; b < 11; b++) begin
        @(negedge mclk_i) drv_o = f[b];
        repeat (DIV - 1) @(negedge mclk_i);
      end
    end
    r = {};
    idle = 0;
    // The line is sampled on the falling edge, away from the edge that launches it.
    while (idle < 60 * DIV) begin
      @(negedge mclk_i);
      idle++;
      if (!line_i) begin
        repeat (DIV / 2) @(negedge mclk_i);
        for (int b = 0; b < 9; b++) begin
          repeat (DIV) @(negedge mclk_i);
          if (b < 8) v[b] = line_i;
        end
        r.push_back(v);
        idle = 0;
      end
    end
    if (r.size() > 2 && crc(r) == 16'h0000) r = r[0:$-2];
    else if (r.size() > 0) r = '{8'hEE};
  endtask
endmodule
`default_nettype wire

// ### testbench/serial_slave_register_map_tb_top.sv
// Purpose: Self-checking bench of the serial slave.
// Assumes: Fixed mode, ten clocks per bit, master on the first port.
// Notes:   Core words read as A3, A2, A1 or F1, F2 followed by the value index.
`timescale 1ns/100ps
`default_nettype none
module serial_slave_register_map_tb_top;
  import ssrm_pkg::*;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        drv, line, oe1, tx1, wr;
  logic [4:0]  vidx, widx;
  logic [47:0] wdata;
  logic [7:0]  saddr = 8'h00;
  logic        com2 = 1'b0;
  ssrm_area_e  warea;
  int          fails = 0, n_compared = 0, cyc = 0, wr_cnt = 0;
  always #2 mclk_i = ~mclk_i;
  assign line = oe1 ? tx1 : drv;
  ssrm_slave #(.DEFAULT_BAUD(25_000_000), .MIN_PULSE(4)) i_dut (.mclk_i(mclk_i), .rst_i(rst_i),
    .port_protocol_select_i(MODE_FIXED), .parity_mode_i(PAR_NONE), .baud_div_i(18'h0000A),
    .slave_addr_i(saddr), .com1_rs485_i(1'b1), .master_on_com2_i(com2), .expansion_link_i(1'b1),
    .rs232_rxd_i(line), .rs232_txd_o(), .com1_485_rxd_i(line), .com1_485_txd_o(tx1),
    .com1_485_oe_o(oe1), .com2_485_rxd_i(line), .com2_485_txd_o(), .com2_485_oe_o(),
    .val_idx_o(vidx), .val_int_i({8'hA3, 3'h0, vidx, 8'hA2, 3'h0, vidx, 8'hA1, 3'h0, vidx}),
    .val_flt_i({8'hF1, 3'h0, vidx, 8'hF2, 3'h0, vidx}),
    .wr_o(wr), .wr_idx_o(widx), .wr_area_o(warea), .wr_data_o(wdata));
  ssrm_master #(.DIV(10)) i_master (.mclk_i(mclk_i), .line_i(line), .drv_o(drv));
  always @(posedge mclk_i) if (wr === 1'b1) wr_cnt <= wr_cnt + 1;
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ex(input logic [7:0] q[$], input logic [7:0] e[$]);
    logic [7:0] r[$];
    i_master.xfer(q, r);
    chk(48'(r.size()), 48'(e.size()));
    foreach (e[i]) if (i < r.size()) chk(48'(r[i]), 48'(e[i]));
  endtask
  task automatic t_areas;
    ex('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h01, 8'h03, 8'h02, 8'hA1, 8'h00});
    ex('{8'h01, 8'h03, 8'h00, 8'hC7, 8'h00, 8'h02}, '{8'h01, 8'h03, 8'h04, 8'hF1, 8'h00, 8'hF2, 8'h00});
    ex('{8'h01, 8'h03, 8'h14, 8'h4F, 8'h00, 8'h02}, '{8'h01, 8'h03, 8'h04, 8'hF2, 8'h00, 8'hF1, 8'h00});
    ex('{8'h01, 8'h03, 8'h00, 8'h1D, 8'h00, 8'h01}, '{8'h01, 8'h03, 8'h02, 8'h00, 8'h00});
  endtask
  task automatic t_block;
    ex('{8'h01, 8'h03, 8'h00, 8'h06, 8'h00, 8'h03},
       '{8'h01, 8'h03, 8'h06, 8'h00, 8'h00, 8'hA1, 8'h05, 8'hA1, 8'h06});
    ex('{8'h01, 8'h03, 8'h00, 8'h08, 8'h00, 8'h06}, '{8'h01, 8'h03, 8'h0C, 8'hA1, 8'h06,
       8'hA1, 8'h07, 8'hA1, 8'h08, 8'hA3, 8'h09, 8'hA2, 8'h09, 8'hA1, 8'h09});
  endtask
  task automatic t_write;
    int n = wr_cnt;
    ex('{8'h01, 8'h05, 8'h00, 8'h1D, 8'h00, 8'h07}, '{8'h01, 8'h05, 8'h00, 8'h1D, 8'h00, 8'h07});
    chk({43'h0, widx}, 48'h0F);
    chk({32'h0, wdata[15:0]}, 48'h7);
    ex('{8'h01, 8'h10, 8'h00, 8'h1E, 8'h00, 8'h03, 8'h06, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9A, 8'hBC},
       '{8'h01, 8'h10, 8'h00, 8'h1E, 8'h00, 8'h03});
    chk(wdata, 48'h123456789ABC);
    chk({46'h0, warea}, {46'h0, AREA_INT});
    ex('{8'h01, 8'h05, 8'h00, 8'h2C, 8'h00, 8'h01}, '{8'h01, 8'h05, 8'h00, 8'h2C, 8'h00, 8'h01});
    chk(48'(wr_cnt - n), 48'h2);
  endtask
  task automatic t_faults;
    ex('{8'h01, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h01, 8'h85, 8'h03});
    ex('{8'h01, 8'h03, 8'h00, 8'h06, 8'h00, 8'h01}, '{8'h01, 8'h03, 8'h02, 8'h00, 8'h65});
    ex('{8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h01, 8'h84, 8'h01});
    ex('{8'h02, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{});
  endtask
  task automatic t_config;
    @(negedge mclk_i);
    com2  = 1'b1;
    saddr = 8'h02;
    ex('{8'h02, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h02, 8'h03, 8'h02, 8'hA1, 8'h00});
    ex('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{});
  endtask
  task automatic summarize;
    if (fails == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Fifteen exchanges of about 2800 cycles each fit below this ceiling.
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(negedge mclk_i);
    rst_i = 1'b0;
    t_areas();
    t_block();
    t_write();
    t_faults();
    t_config();
    summarize();
  end
endmodule
`default_nettype wire
